// ===== ahb_host_model.sv
// Host-side bus master driving single-word transfers
`timescale 1ns/1ps
module ahb_host_model (
    // Clock and slave answer
    input wire logic clk_sys_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_i,
    // Request
    output logic hsel_o,
    output logic [7:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [2:0] hsize_o,
    output logic [31:0] hwdata_o
);
    // Idle bus, whole-word size
    initial begin
        {hsel_o, haddr_o, htrans_o, hwrite_o, hwdata_o} = '0;
        hsel_o = 1'b1;
        hsize_o = 3'h2;
    end
    // Wait for hready under a bound
    task automatic wait_rdy(inout logic ok);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (hready_i !== 1'b1 && n < 64);
        ok = ok & (hready_i === 1'b1);
    endtask
    // One transfer; host may send any code the bench asks for
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic ok);
        ok = 1'b1;
        haddr_o <= a;
        hwrite_o <= w;
        htrans_o <= 2'b10;
        wait_rdy(ok);
        htrans_o <= 2'b00;
        hwdata_o <= w ? d : ~hwdata_o;
        wait_rdy(ok);
        q = hrdata_i;
        hwdata_o <= ~d; // Released data stops showing the last value
    endtask
endmodule // ahb_host_model

// ===== pump_map_checker.sv
// Port-level checks for the pump mapper
`timescale 1ns/1ps
module pump_map_checker (
    // Clock, reset, bus
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    // Pump side
    input wire logic warning_i,
    input wire logic accelerating_state_i,
    input wire logic warn_report_o,
    input wire logic acc_overtime_o,
    input wire logic low_speed_o,
    input wire logic [10:0] speed_target_o,
    input wire logic [6:0] power_limit_o
);
    logic rd_ph_ff; // Read data phase under way
    // Follow the read data phase
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rd_ph_ff <= 1'b0;
        end else if (ce_i) begin
            rd_ph_ff <= hsel_i & hready_i & htrans_i[1] & ~hwrite_i;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    bus_okay_a: assert property (hreadyout_o && !hresp_o)
        else $error("bus answer not ready or not OKAY");
    rd_quiet_a: assert property (!rd_ph_ff |-> hrdata_o == 32'h0)
        else $error("read data outside a read data phase");
    power_range_a: assert property (power_limit_o inside {[1:100]})
        else $error("power limit outside 1 to 100");
    normal_tgt_a: assert property (!low_speed_o ##1 !low_speed_o
        |-> speed_target_o == 11'h3E8) else $error("normal target not 1000");
    low_tgt_a: assert property (low_speed_o ##1 low_speed_o
        |-> speed_target_o inside {[250:1000]}) else $error("low target");
    warn_gate_a: assert property (!warning_i |=> !warn_report_o)
        else $error("warning reported without a warning");
    acc_clear_a: assert property (!accelerating_state_i
        ##1 !accelerating_state_i |-> !acc_overtime_o)
        else $error("overtime held after acceleration ended");
    acc_early_a: assert property ($rose(accelerating_state_i)
        |=> !acc_overtime_o [*8]) else $error("overtime flagged early");
endmodule // pump_map_checker
bind pump_output_mapper_fault_log pump_map_checker chk_u (
    .clk_sys_i, .rst_i, .ce_i, .hsel_i, .htrans_i, .hwrite_i, .hready_i,
    .hrdata_o, .hreadyout_o, .hresp_o, .warning_i, .accelerating_state_i,
    .warn_report_o, .acc_overtime_o, .low_speed_o, .speed_target_o,
    .power_limit_o
);

// ===== pump_map_consts.svh
// Constants for the pump output mapper and fault log formatter
`ifndef PUMP_MAP_CONSTS_SVH
`define PUMP_MAP_CONSTS_SVH
// Register byte offsets
`define OFS_SPEED_MODE   8'h00
`define OFS_LOW_PCT      8'h04
`define OFS_LOW_TENTH    8'h08
`define OFS_WARN_EN      8'h0C
`define OFS_RELAY1_MODE  8'h10
`define OFS_RELAY2_MODE  8'h14
`define OFS_STAT1_SEL    8'h18
`define OFS_STAT2_SEL    8'h1C
`define OFS_ANALOG_SEL   8'h20
`define OFS_ACC_LIMIT    8'h24
`define OFS_POWER_LIMIT  8'h28
`define OFS_STATUS       8'h2C
`define OFS_SPEED_TGT    8'h30
`define OFS_REC_CTRL     8'h34
`define OFS_REC_BASE     8'h40
`define OFS_REC_LAST     8'h7C
// Reset values
`define RST_LOW_TENTH    11'h3E8
`define RST_WARN_EN      1'h1
`define RST_RELAY1       3'h4
`define RST_RELAY2       3'h0
`define RST_STAT1        4'h0
`define RST_STAT2        4'h1
`define RST_ANALOG       3'h0
`define RST_ACC_LIMIT    11'h1E0
`define RST_POWER        7'h64
// Ranges
`define MAX_RELAY1       3'h4
`define MAX_RELAY2       3'h3
`define MAX_STAT         4'h8
`define MAX_ANALOG       3'h5
`define MIN_LOW_TENTH    11'h0FA
`define MAX_LOW_TENTH    11'h3E8
`define MIN_LOW_PCT      7'h19
`define MAX_LOW_PCT      7'h64
`define MIN_ACC          11'h12C
`define MAX_ACC          11'h708
`define MAX_POWER        7'h64
`define MIN_POWER        7'h01
`define FULL_TENTH       11'h3E8
// Analog full scale
`define FS_SPEED         16'h0064
`define FS_CURRENT       16'h0096
`define FS_TEMP          16'h0096
`define DAC_FULL         12'hFFF
// Cycles per second at 125 MHz
`define SEC_CYC          27'd125000000
// Record index reset value and range
`define RST_INDEX        7'h01
`define RST_INDEX_BCD    8'h01
`define MIN_INDEX        7'h01
`define MAX_INDEX        7'h63
// Record character code of digit zero
`define ASCII_ZERO       8'h30
`endif

// ===== pump_map_pkg.sv
// Types for the pump output mapper and fault log formatter
package pump_map_pkg;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_READ = 2'b10
    } bus_phase_t;
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_RUN = 2'b01,
        ACC_DONE = 2'b10,
        ACC_FAULT = 2'b11
    } acc_state_t;
endpackage

// ===== pump_output_mapper_fault_log.sv
// Output mapping, settings and fault record formatting for the pump
//
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "pump_map_consts.svh"

module pump_output_mapper_fault_log (
    // Clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [7:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Pump state
    input wire logic digital_in_first_i,
    input wire logic digital_in_second_i,
    input wire logic normal_speed_i,
    input wire logic alarm_i,
    input wire logic warning_i,
    input wire logic accelerating_state_i,
    input wire logic idle_i,
    input wire logic vent_ctrl_i,
    input wire logic [6:0] speed_pct_i,
    input wire logic [7:0] current_tenth_i,
    input wire logic [7:0] motor_temp_i,
    input wire logic [7:0] bearing_temp_i,
    // Fault snapshot, BCD digits except fault_state_i, which holds two ASCII characters
    input wire logic [7:0] fault_time_yy_i,
    input wire logic [7:0] fault_time_mo_i,
    input wire logic [7:0] fault_time_dd_i,
    input wire logic [7:0] fault_time_hh_i,
    input wire logic [7:0] fault_time_mi_i,
    input wire logic [7:0] fault_code_i,
    input wire logic [15:0] fault_state_i,
    input wire logic [15:0] fault_speed_i,
    input wire logic [15:0] fault_current_i,
    input wire logic [23:0] fault_hours_i,
    // Outputs to equipment
    output logic relay_out_first_o,
    output logic relay_out_second_o,
    output logic status_out_first_o,
    output logic status_out_second_o,
    output logic warn_report_o,
    output logic [11:0] analog_out_o,
    output logic low_speed_o,
    output logic [10:0] speed_target_o,
    output logic [6:0] power_limit_o,
    output logic acc_overtime_o
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------

    // BCD digit pair to ASCII characters
    function automatic logic [15:0] bcd2asc(input logic [7:0] b);
        bcd2asc = {`ASCII_ZERO | {4'h0, b[7:4]},
                   `ASCII_ZERO | {4'h0, b[3:0]}};
    endfunction
    // Scale a value to the 12-bit analog range, saturating
    function automatic logic [11:0] scale(input logic [15:0] v,
                                          input logic [15:0] fs);
        logic [27:0] p;
        p = 28'(v) * 28'(`DAC_FULL);
        scale = (v >= fs) ? `DAC_FULL : 12'(p / 28'(fs));
    endfunction
    // ------------------------------------------------------------
    // Settings storage
    // ------------------------------------------------------------
    logic speed_mode_ff; // Low speed selected
    logic [10:0] low_tenth_ff; // Low speed in tenths of percent
    logic warn_en_ff; // Warning report enable
    logic [2:0] relay1_ff; // First relay mode
    logic [2:0] relay2_ff; // Second relay mode
    logic [3:0] stat1_ff; // First status source
    logic [3:0] stat2_ff; // Second status source
    logic [2:0] analog_ff; // Analog source
    logic [10:0] acc_limit_ff; // Acceleration limit, seconds
    logic [6:0] power_ff; // Power limit percent
    logic [6:0] index_ff; // Record index, 1 to 99
    logic [7:0] index_bcd_ff; // Index as BCD

    // Bus phase state
    pump_map_pkg::bus_phase_t phase_ff;
    logic [7:0] addr_ff; // Latched address
    logic [31:0] wdat; // Write data alias
    logic [31:0] nxt_rdata; // Read mux

    // ------------------------------------------------------------
    // AHB-Lite address phase capture
    // ------------------------------------------------------------
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign wdat = hwdata_i;

    // Latch a valid transfer, word accesses only are issued
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            phase_ff <= pump_map_pkg::BUS_IDLE;
            addr_ff <= 8'h00;
        end else if (ce_i) begin
            if (hsel_i && hready_i && htrans_i[1]) begin
                phase_ff <= hwrite_i ? pump_map_pkg::BUS_WRITE
                                     : pump_map_pkg::BUS_READ;
                addr_ff <= haddr_i;
            end else if (hready_i) begin
                phase_ff <= pump_map_pkg::BUS_IDLE;
            end
        end
    end
    logic wr; // Write data phase
    assign wr = (phase_ff == pump_map_pkg::BUS_WRITE);

    // ------------------------------------------------------------
    // Setting writes with range check
    // ------------------------------------------------------------

    // Speed mode and low-speed value, both forms share one store
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            speed_mode_ff <= 1'b0;
            low_tenth_ff <= `RST_LOW_TENTH;
        end else if (ce_i && wr) begin
            if (addr_ff == `OFS_SPEED_MODE && wdat[31:1] == 31'h0)
                speed_mode_ff <= wdat[0];
            if (addr_ff == `OFS_LOW_TENTH && wdat[31:11] == 21'h0 &&
                wdat[10:0] >= `MIN_LOW_TENTH &&
                wdat[10:0] <= `MAX_LOW_TENTH) begin
                low_tenth_ff <= wdat[10:0];
            end
            if (addr_ff == `OFS_LOW_PCT && wdat[31:7] == 25'h0 &&
                wdat[6:0] >= `MIN_LOW_PCT &&
                wdat[6:0] <= `MAX_LOW_PCT) begin
                low_tenth_ff <= 11'(wdat[6:0] * 4'hA);
            end
        end
    end
    // Output mode settings
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            warn_en_ff <= `RST_WARN_EN;
            relay1_ff <= `RST_RELAY1;
            relay2_ff <= `RST_RELAY2;
            stat1_ff <= `RST_STAT1;
            stat2_ff <= `RST_STAT2;
            analog_ff <= `RST_ANALOG;
        end else if (ce_i && wr) begin
            // Each code is kept only when it lies in its allowed range
            if (addr_ff == `OFS_WARN_EN && wdat[31:1] == 31'h0)
                warn_en_ff <= wdat[0];
            if (addr_ff == `OFS_RELAY1_MODE && wdat <= 32'(`MAX_RELAY1))
                relay1_ff <= wdat[2:0];
            if (addr_ff == `OFS_RELAY2_MODE && wdat <= 32'(`MAX_RELAY2))
                relay2_ff <= wdat[2:0];
            if (addr_ff == `OFS_STAT1_SEL && wdat <= 32'(`MAX_STAT))
                stat1_ff <= wdat[3:0];
            if (addr_ff == `OFS_STAT2_SEL && wdat <= 32'(`MAX_STAT))
                stat2_ff <= wdat[3:0];
            if (addr_ff == `OFS_ANALOG_SEL && wdat <= 32'(`MAX_ANALOG))
                analog_ff <= wdat[2:0];
        end
    end
    // Timing and power settings, record index
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            acc_limit_ff <= `RST_ACC_LIMIT;
            power_ff <= `RST_POWER;
            index_ff <= `RST_INDEX;
            index_bcd_ff <= `RST_INDEX_BCD;
        end else if (ce_i && wr) begin
            if (addr_ff == `OFS_ACC_LIMIT && wdat >= 32'(`MIN_ACC) &&
                wdat <= 32'(`MAX_ACC))
                acc_limit_ff <= wdat[10:0];
            if (addr_ff == `OFS_POWER_LIMIT && wdat >= 32'(`MIN_POWER) &&
                wdat <= 32'(`MAX_POWER))
                power_ff <= wdat[6:0];
            if (addr_ff == `OFS_REC_CTRL && wdat >= 32'(`MIN_INDEX) &&
                wdat <= 32'(`MAX_INDEX)) begin
                index_ff <= wdat[6:0];
                index_bcd_ff <= {4'(wdat[6:0] / 7'hA),
                                 4'(wdat[6:0] % 7'hA)};
            end
        end
    end

    // ------------------------------------------------------------
    // Output mapping
    // ------------------------------------------------------------
    logic warn_q; // Warning after report gate
    assign warn_q = warning_i & warn_en_ff;
    // Status source decode, used for both outputs
    function automatic logic stat_pick(input logic [3:0] s,
        input logic nrm, input logic alm, input logic wrn,
        input logic acc, input logic idl);
        case (s)
            4'h0: stat_pick = nrm;
            4'h1: stat_pick = alm;
            4'h2: stat_pick = ~alm;
            4'h3: stat_pick = wrn;
            4'h4: stat_pick = ~wrn;
            4'h5: stat_pick = acc;
            4'h6: stat_pick = idl;
            4'h7: stat_pick = 1'b1;
            default: stat_pick = 1'b0;
        endcase
    endfunction
    // Relay mode decode, code 4 only reachable on the first relay
    function automatic logic relay_pick(input logic [2:0] m,
        input logic di, input logic vent);
        case (m)
            3'h0: relay_pick = di;
            3'h1: relay_pick = ~di;
            3'h2: relay_pick = 1'b1;
            3'h4: relay_pick = vent;
            default: relay_pick = 1'b0;
        endcase
    endfunction
    logic [11:0] nxt_analog; // Analog next value
    // Analog source and full-scale mapping
    always_comb begin
        case (analog_ff)
            3'h0: nxt_analog = scale({9'h0, speed_pct_i},
                                     `FS_SPEED);
            3'h1: nxt_analog = scale({8'h0, current_tenth_i},
                                     `FS_CURRENT);
            3'h2: nxt_analog = scale({8'h0, motor_temp_i},
                                     `FS_TEMP);
            3'h3: nxt_analog = scale({8'h0, bearing_temp_i},
                                     `FS_TEMP);
            3'h4: nxt_analog = 12'h000;
            default: nxt_analog = `DAC_FULL;
        endcase
    end

    // Registered drive outputs
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            relay_out_first_o <= 1'b0;
            relay_out_second_o <= 1'b0;
            status_out_first_o <= 1'b0;
            status_out_second_o <= 1'b0;
            warn_report_o <= 1'b0;
            analog_out_o <= 12'h000;
            low_speed_o <= 1'b0;
            speed_target_o <= `FULL_TENTH;
            power_limit_o <= `RST_POWER;
        end else if (ce_i) begin
            relay_out_first_o <= relay_pick(relay1_ff,
                digital_in_first_i, vent_ctrl_i);
            relay_out_second_o <= relay_pick(relay2_ff,
                digital_in_second_i, 1'b0);
            status_out_first_o <= stat_pick(stat1_ff, normal_speed_i,
                alarm_i, warn_q, accelerating_state_i, idle_i);
            status_out_second_o <= stat_pick(stat2_ff, normal_speed_i,
                alarm_i, warn_q, accelerating_state_i, idle_i);
            warn_report_o <= warn_q;
            analog_out_o <= nxt_analog;
            low_speed_o <= speed_mode_ff;
            speed_target_o <= speed_mode_ff ? low_tenth_ff
                                            : `FULL_TENTH;
            power_limit_o <= power_ff;
        end
    end

    // ------------------------------------------------------------
    // Acceleration overtime watch
    // ------------------------------------------------------------
    pump_map_pkg::acc_state_t acc_ff;
    logic [26:0] tick_ff; // Cycles within one second
    logic [10:0] secs_ff; // Seconds accelerating
    // Count seconds while accelerating, flag when limit passes
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            acc_ff <= pump_map_pkg::ACC_IDLE;
            tick_ff <= 27'd0;
            secs_ff <= 11'h000;
        end else if (ce_i) begin
            case (acc_ff)
                pump_map_pkg::ACC_IDLE: begin
                    tick_ff <= 27'd0;
                    secs_ff <= 11'h000;
                    if (accelerating_state_i) begin
                        acc_ff <= pump_map_pkg::ACC_RUN;
                    end
                end
                pump_map_pkg::ACC_RUN: begin
                    if (!accelerating_state_i) begin
                        acc_ff <= pump_map_pkg::ACC_IDLE;
                    end else if (secs_ff >= acc_limit_ff) begin
                        acc_ff <= pump_map_pkg::ACC_FAULT;
                    end else if (tick_ff == `SEC_CYC - 27'd1) begin
                        tick_ff <= 27'd0;
                        secs_ff <= secs_ff + 11'h001;
                    end else begin
                        tick_ff <= tick_ff + 27'd1;
                    end
                end
                pump_map_pkg::ACC_FAULT: begin
                    if (!accelerating_state_i) begin
                        acc_ff <= pump_map_pkg::ACC_IDLE;
                    end
                end
                default: acc_ff <= pump_map_pkg::ACC_IDLE;
            endcase
        end
    end
    assign acc_overtime_o = (acc_ff == pump_map_pkg::ACC_FAULT);

    // ------------------------------------------------------------
    // Fault record assembly
    // ------------------------------------------------------------
    logic [511:0] rec; // 64 ASCII characters, first in top byte
    logic [31:0] zero4; // Four zero characters
    assign zero4 = {4{`ASCII_ZERO}};
    // Fields in order with unused fields zero-filled
    assign rec = {
        bcd2asc(index_bcd_ff),
        bcd2asc(fault_time_yy_i), bcd2asc(fault_time_mo_i),
        bcd2asc(fault_time_dd_i), bcd2asc(fault_time_hh_i),
        bcd2asc(fault_time_mi_i),
        bcd2asc(fault_code_i),
        fault_state_i,
        bcd2asc(fault_speed_i[15:8]),
        bcd2asc(fault_speed_i[7:0]),
        bcd2asc(fault_current_i[15:8]),
        bcd2asc(fault_current_i[7:0]),
        {6{`ASCII_ZERO}}, {7{zero4}},
        bcd2asc(fault_hours_i[23:16]), bcd2asc(fault_hours_i[15:8]),
        bcd2asc(fault_hours_i[7:0])
    };

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [3:0] rec_word; // Record word index
    assign rec_word = 4'(addr_ff[5:2]);

    // Register read mux
    always_comb begin
        nxt_rdata = 32'h0;
        case (addr_ff)
            `OFS_SPEED_MODE: nxt_rdata = {31'h0, speed_mode_ff};
            `OFS_LOW_PCT: nxt_rdata = 32'(low_tenth_ff / 11'hA);
            `OFS_LOW_TENTH: nxt_rdata = {21'h0, low_tenth_ff};
            `OFS_WARN_EN: nxt_rdata = {31'h0, warn_en_ff};
            `OFS_RELAY1_MODE: nxt_rdata = {29'h0, relay1_ff};
            `OFS_RELAY2_MODE: nxt_rdata = {29'h0, relay2_ff};
            `OFS_STAT1_SEL: nxt_rdata = {28'h0, stat1_ff};
            `OFS_STAT2_SEL: nxt_rdata = {28'h0, stat2_ff};
            `OFS_ANALOG_SEL: nxt_rdata = {29'h0, analog_ff};
            `OFS_ACC_LIMIT: nxt_rdata = {21'h0, acc_limit_ff};
            `OFS_POWER_LIMIT: nxt_rdata = {25'h0, power_ff};
            `OFS_STATUS: nxt_rdata = {28'h0, acc_overtime_o,
                warn_q, alarm_i, accelerating_state_i};
            `OFS_SPEED_TGT: nxt_rdata = {21'h0, speed_target_o};
            `OFS_REC_CTRL: nxt_rdata = {25'h0, index_ff};
            default: begin
                if (addr_ff >= `OFS_REC_BASE && addr_ff <= `OFS_REC_LAST)
                    nxt_rdata = rec[511 - 32 * rec_word -: 32];
            end
        endcase
    end

    // Read data is combinational in the data phase
    assign hrdata_o = (phase_ff == pump_map_pkg::BUS_READ) ? nxt_rdata
                                                          : 32'h0;

endmodule // pump_output_mapper_fault_log

// ===== testbench.sv
// Self-checking bench for the pump mapper and fault record
`timescale 1ns/1ps
module testbench;
    logic clk_sys_i, rst_i, ce_i, hsel_i, hwrite_i, hready_i, hresp_o;
    logic hreadyout_o, normal_speed_i, alarm_i, warning_i, idle_i;
    logic [7:0] haddr_i, current_tenth_i, motor_temp_i, bearing_temp_i;
    logic [1:0] htrans_i;
    logic [2:0] hsize_i;
    logic [31:0] hwdata_i, hrdata_o;
    logic digital_in_first_i, digital_in_second_i, vent_ctrl_i;
    logic accelerating_state_i, relay_out_first_o, relay_out_second_o;
    logic status_out_first_o, status_out_second_o, warn_report_o;
    logic low_speed_o, acc_overtime_o;
    logic [6:0] speed_pct_i, power_limit_o;
    logic [11:0] analog_out_o;
    logic [10:0] speed_target_o;
    logic [119:0] snap;
    int mismatches, n_tests;
    localparam logic [31:0] RV [14] = '{32'h0, 32'h64, 32'h3E8, 32'h1,
        32'h4, 32'h0, 32'h0, 32'h1, 32'h0, 32'h1E0, 32'h64, 32'h0, 32'h3E8,
        32'h1};
    localparam logic [31:0] AN [6] = '{32'h999, 32'hCCC, 32'h333,
        32'hFFF, 32'h0, 32'hFFF};
    localparam logic [511:0] REC = {"07240315123042NS00800023",
        "0000000000000000", "000000000000000000", "012345"};
    assign hready_i = hreadyout_o;
    pump_output_mapper_fault_log dut_u (
        .clk_sys_i, .rst_i, .ce_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
        .hsize_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o,
        .digital_in_first_i, .digital_in_second_i, .normal_speed_i,
        .alarm_i, .warning_i, .accelerating_state_i, .idle_i, .vent_ctrl_i,
        .speed_pct_i, .current_tenth_i, .motor_temp_i, .bearing_temp_i,
        .fault_time_yy_i(snap[119:112]), .fault_time_mo_i(snap[111:104]),
        .fault_time_dd_i(snap[103:96]), .fault_time_hh_i(snap[95:88]),
        .fault_time_mi_i(snap[87:80]), .fault_code_i(snap[79:72]),
        .fault_state_i(snap[71:56]), .fault_speed_i(snap[55:40]),
        .fault_current_i(snap[39:24]), .fault_hours_i(snap[23:0]),
        .relay_out_first_o, .relay_out_second_o, .status_out_first_o,
        .status_out_second_o, .warn_report_o, .analog_out_o, .low_speed_o,
        .speed_target_o, .power_limit_o, .acc_overtime_o);
    ahb_host_model host_u (.clk_sys_i, .hready_i, .hrdata_i(hrdata_o),
        .hsel_o(hsel_i), .haddr_o(haddr_i), .htrans_o(htrans_i),
        .hwrite_o(hwrite_i), .hsize_o(hsize_i), .hwdata_o(hwdata_i));
    // 125 MHz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    // Verdict and end of run
    task automatic test_done;
        if (mismatches == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Bus access; a hung slave ends the run
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, e);
        logic [31:0] q;
        logic ok;
        host_u.xfer(w, a, d, q, ok);
        if (!ok) begin
            mismatches++;
            test_done();
        end
        if (!w) cmp($sformatf("register %h", a), e, q);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 32'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, e);
    endtask
    task automatic settle;
        repeat (3) @(posedge clk_sys_i);
    endtask
    // Expected relay level for a mode code
    function automatic logic ry(int m, logic di, logic vt);
        return m == 0 ? di : m == 1 ? !di : m == 2 ? 1'b1 : m == 3 ? 1'b0 : vt;
    endfunction
    // Expected status output for a source code, warnings enabled
    function automatic logic so(int c);
        logic [8:0] v;
        v = {1'b0, 1'b1, idle_i, accelerating_state_i, !warning_i,
             warning_i, !alarm_i, alarm_i, normal_speed_i};
        return v[c];
    endfunction
    initial begin
        {rst_i, ce_i, digital_in_first_i, digital_in_second_i, vent_ctrl_i,
         normal_speed_i, alarm_i, warning_i, accelerating_state_i} = 9'h180;
        {idle_i, speed_pct_i, current_tenth_i, motor_temp_i} = '0;
        bearing_temp_i = 8'h00;
        snap = {40'h2403151230, 8'h42, "NS", 16'h80, 16'h23, 24'h012345};
        {mismatches, n_tests} = '0;
        repeat (20) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 14; i++) rd(8'(4 * i), RV[i]);
        rd(8'h3C, 32'h0);
        wr(8'h04, 32'h19);
        rd(8'h08, 32'hFA);
        wr(8'h08, 32'h323);
        rd(8'h04, 32'h50);
        wr(8'h08, 32'hF9);
        wr(8'h04, 32'h65);
        wr(8'h00, 32'h1);
        settle();
        cmp("speed target", 32'h323, speed_target_o);
        wr(8'h00, 32'h0);
        for (int m = 0; m < 5; m++) begin
            wr(8'h10, 32'(m));
            wr(8'h14, 32'(m));
            for (int d = 0; d < 2; d++) begin
                {digital_in_first_i, digital_in_second_i} <= {2{d[0]}};
                vent_ctrl_i <= !d[0];
                settle();
                cmp("relay one", ry(m, d[0], !d[0]),
                    relay_out_first_o);
                cmp("relay two", ry(m > 3 ? 3 : m, d[0], 0),
                    relay_out_second_o);
            end
        end
        for (int c = 0; c < 9; c++) begin
            wr(8'h18, 32'(c));
            wr(8'h1C, 32'(8 - c));
            for (int p = 0; p < 2; p++) begin
                {normal_speed_i, alarm_i, warning_i, accelerating_state_i,
                 idle_i} <= p[0] ? 5'h15 : 5'h0A;
                settle();
                cmp("status one", so(c), status_out_first_o);
                cmp("status two", so(8 - c), status_out_second_o);
            end
        end
        cmp("warn report", 32'h1, warn_report_o);
        wr(8'h18, 32'h3);
        wr(8'h0C, 32'h0);
        settle();
        cmp("warn report", 32'h0, warn_report_o);
        cmp("status gated", 32'h0, status_out_first_o);
        {speed_pct_i, current_tenth_i} <= {7'h3C, 8'h78};
        {motor_temp_i, bearing_temp_i} <= {8'h1E, 8'h96};
        for (int a = 0; a < 6; a++) begin
            wr(8'h20, 32'(a));
            settle();
            cmp("analog", AN[a], analog_out_o);
        end
        // A write while the enable is low must not land
        ce_i <= 1'b0;
        wr(8'h20, 32'h4);
        ce_i <= 1'b1;
        settle();
        cmp("frozen analog", 32'hFFF, analog_out_o);
        wr(8'h28, 32'h32);
        wr(8'h28, 32'h65);
        settle();
        cmp("power", 32'h32, power_limit_o);
        wr(8'h24, 32'h12B);
        rd(8'h24, 32'h1E0);
        wr(8'h34, 32'h7);
        wr(8'h34, 32'h64);
        for (int i = 0; i < 16; i++)
            rd(8'(64 + 4 * i), REC[511 - 32 * i -: 32]);
        test_done();
    end
endmodule // testbench
